// >>> design/urx_pkg.sv
// Constants, register map and state encoding for the serial receiver
`default_nettype none
package urx_pkg;
   // Register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int WORD_W = 9;

   // Register offsets (byte addresses)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_BAUD = 4'h4;
   localparam logic [3:0] ADDR_STAT = 4'h8;
   localparam logic [3:0] ADDR_DATA = 4'hC;

   // Fields of serial_ctrl_one
   localparam int CTRL_W = 6;
   localparam int CB_RX_EN = 0;
   localparam int CB_WL9 = 1;
   localparam int CB_PAR_EN = 2;
   localparam int CB_PAR_ODD = 3;
   localparam int CB_STOP2 = 4;
   localparam int CB_INT_EN = 5;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [15:0] BAUD_RST = 16'h0000;

   // Fields of serial_status_reg
   localparam int SB_AVAIL = 0;
   localparam int SB_IDLE = 1;
   localparam int SB_OVR = 2;
   localparam int SB_NOISE = 3;
   localparam int SB_FRAME_ERR_FLAG = 4;
   localparam int SB_PARITY_ERR_FLAG = 5;
   localparam int SB_NINTH = 6;

   // Oversampling phases within one bit period, and word lengths in bits
   localparam logic [3:0] PH_FIRST = 4'h0;
   localparam logic [3:0] PH_SAMP_LO = 4'h7;
   localparam logic [3:0] PH_SAMP_HI = 4'h9;
   localparam logic [3:0] PH_VOTE = 4'hA;
   localparam logic [3:0] PH_LAST = 4'hF;
   localparam logic [3:0] BITS_8 = 4'h8;
   localparam logic [3:0] BITS_9 = 4'h9;

   typedef enum logic [5:0] {
      URX_HUNT = 6'h01,
      URX_START = 6'h02,
      URX_DATA = 6'h04,
      URX_STOP = 6'h08,
      URX_STOP2 = 6'h10,
      URX_WAITHI = 6'h20
   } urx_state_t;
endpackage
`default_nettype wire

// >>> design/urx_line_filt.sv
// Line input synchroniser and three-sample majority voter
`default_nettype none
module urx_line_filt (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   // Raw serial line
   input wire logic rx_pin,
   // Sample strobe and results
   input wire logic samp_en,
   output logic line,
   output logic maj,
   output logic noisy
);
   logic s1;
   logic s2;
   logic s3;
   logic [2:0] samp;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
      end else if (ce) begin
         s1 <= rx_pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A change counts only once the last two stages agree
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         line <= 1'b1;
      end else if (ce && (s2 == s3)) begin
         line <= s3;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         samp <= 3'h7;
      end else if (ce && samp_en) begin
         samp <= {samp[1:0], line};
      end
   end

   assign maj = (samp[0] & samp[1]) | (samp[1] & samp[2]) | (samp[0] & samp[2]);
   assign noisy = (samp != 3'h0) && (samp != 3'h7);
endmodule
`default_nettype wire

// >>> design/urx_receiver.sv
// Receive half of an asynchronous serial port with two-word buffer
`default_nettype none
module urx_receiver #(
   parameter int DEPTH = 2
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   // Register port
   input wire logic [urx_pkg::ADDR_W-1:0] addr,
   input wire logic [urx_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [urx_pkg::DATA_W-1:0] rd_data,
   // Serial line and receive request
   input wire logic rx_pin,
   output logic rx_irq
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam int ENT_W = urx_pkg::WORD_W + 3;

   logic [urx_pkg::CTRL_W-1:0] serial_ctrl_one;
   logic [urx_pkg::DATA_W-1:0] baud_divisor;
   logic [urx_pkg::DATA_W-1:0] div_cnt;
   urx_pkg::urx_state_t state;
   logic [3:0] phase;
   logic [3:0] bit_cnt;
   logic [urx_pkg::WORD_W-1:0] rx_shift_reg;
   logic noise_acc;
   logic line;
   logic line_prev;
   logic maj;
   logic noisy;
   logic push;
   logic [ENT_W-1:0] push_ent;
   logic [ENT_W-1:0] fifo_mem [DEPTH];
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W-1:0] wr_ptr;
   logic [CNT_W-1:0] count;
   logic overrun_flag;
   logic rx_idle_flag;
   logic clr_armed;

   wire rx_enable = serial_ctrl_one[urx_pkg::CB_RX_EN];
   wire word_len_sel = serial_ctrl_one[urx_pkg::CB_WL9];
   wire parity_en = serial_ctrl_one[urx_pkg::CB_PAR_EN];
   wire parity_type_sel = serial_ctrl_one[urx_pkg::CB_PAR_ODD];
   wire stop_two = serial_ctrl_one[urx_pkg::CB_STOP2];
   wire rx_int_en = serial_ctrl_one[urx_pkg::CB_INT_EN];

   wire ovs_tick = (div_cnt == '0);
   wire samp_en = ovs_tick && (phase >= urx_pkg::PH_SAMP_LO) && (phase <= urx_pkg::PH_SAMP_HI);
   wire vote = ovs_tick && (phase == urx_pkg::PH_VOTE);
   wire bit_end = ovs_tick && (phase == urx_pkg::PH_LAST);
   wire start_det = rx_enable && (state == urx_pkg::URX_HUNT) && line_prev && !line;
   wire fin = vote && (((state == urx_pkg::URX_STOP) && !(stop_two && maj))
      || (state == urx_pkg::URX_STOP2));
   wire full = (count == CNT_W'(DEPTH));
   wire avail = (count != '0);
   wire rd_stat = rd_en && (addr == urx_pkg::ADDR_STAT);
   wire rd_dat = rd_en && (addr == urx_pkg::ADDR_DATA);
   wire pop = rd_dat && avail;
   wire push_ok = push && (!full || pop);
   wire ovr_evt = push && full && !pop;
   wire [ENT_W-1:0] head = fifo_mem[rd_ptr];

   // Word as received: 8-bit frames are shifted down into the lower bits
   function automatic logic [urx_pkg::WORD_W-1:0] align_word(
      input logic [urx_pkg::WORD_W-1:0] sr,
      input logic wl9
   );
      align_word = wl9 ? sr : {1'b0, sr[urx_pkg::WORD_W-1:1]};
   endfunction

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
   endfunction

   urx_line_filt u_filt (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .ce(ce),
      .rx_pin(rx_pin),
      .samp_en(samp_en),
      .line(line),
      .maj(maj),
      .noisy(noisy)
   );

   // Control register writes
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         serial_ctrl_one <= urx_pkg::CTRL_RST;
         baud_divisor <= urx_pkg::BAUD_RST;
      end else if (ce && wr_en) begin
         if (addr == urx_pkg::ADDR_CTRL) begin
            serial_ctrl_one <= wr_data[urx_pkg::CTRL_W-1:0];
         end else if (addr == urx_pkg::ADDR_BAUD) begin
            baud_divisor <= wr_data;
         end
      end
   end

   // Sixteen-times oversampling tick from the divisor
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt <= '0;
      end else if (ce) begin
         if (ovs_tick || (state == urx_pkg::URX_HUNT)) begin
            div_cnt <= baud_divisor;
         end else begin
            div_cnt <= div_cnt - urx_pkg::DATA_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         line_prev <= 1'b1;
      end else if (ce) begin
         line_prev <= line;
      end
   end

   // Frame state machine
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= urx_pkg::URX_HUNT;
         phase <= urx_pkg::PH_FIRST;
         bit_cnt <= '0;
         rx_shift_reg <= '0;
         noise_acc <= 1'b0;
      end else if (ce) begin
         if (ovs_tick && (state != urx_pkg::URX_HUNT)) begin
            phase <= phase + 4'h1;
         end
         if (!rx_enable) begin
            state <= urx_pkg::URX_HUNT;
            phase <= urx_pkg::PH_FIRST;
         end else begin
            case (state)
               urx_pkg::URX_HUNT: begin
                  phase <= urx_pkg::PH_FIRST;
                  if (start_det) begin
                     state <= urx_pkg::URX_START;
                     noise_acc <= 1'b0;
                     bit_cnt <= '0;
                  end
               end
               urx_pkg::URX_START: begin
                  if (vote) begin
                     noise_acc <= noisy;
                     if (maj) begin
                        state <= urx_pkg::URX_HUNT;
                     end
                  end else if (bit_end) begin
                     state <= urx_pkg::URX_DATA;
                  end
               end
               urx_pkg::URX_DATA: begin
                  if (vote) begin
                     rx_shift_reg <= {maj, rx_shift_reg[urx_pkg::WORD_W-1:1]};
                     noise_acc <= noise_acc | noisy;
                  end else if (bit_end) begin
                     if (bit_cnt == ((word_len_sel ? urx_pkg::BITS_9 : urx_pkg::BITS_8)
                           - 4'h1)) begin
                        state <= urx_pkg::URX_STOP;
                     end
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
               urx_pkg::URX_STOP: begin
                  if (vote) begin
                     noise_acc <= noise_acc | noisy;
                  end
                  if (fin) begin
                     state <= maj ? urx_pkg::URX_HUNT : urx_pkg::URX_WAITHI;
                  end else if (bit_end) begin
                     state <= urx_pkg::URX_STOP2;
                  end
               end
               urx_pkg::URX_STOP2: begin
                  if (fin) begin
                     state <= maj ? urx_pkg::URX_HUNT : urx_pkg::URX_WAITHI;
                  end
               end
               urx_pkg::URX_WAITHI: begin
                  phase <= urx_pkg::PH_FIRST;
                  if (line) begin
                     state <= urx_pkg::URX_HUNT;
                  end
               end
               default: begin
                  state <= urx_pkg::URX_HUNT;
               end
            endcase
         end
      end
   end

   // Completed frame with its error flags, one cycle after the stop vote
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         push <= 1'b0;
         push_ent <= '0;
      end else if (ce) begin
         push <= fin && rx_enable;
         if (fin) begin
            push_ent[urx_pkg::WORD_W-1:0] <= align_word(rx_shift_reg, word_len_sel);
            push_ent[urx_pkg::WORD_W] <= !maj;
            push_ent[urx_pkg::WORD_W+1] <= parity_en
               && ((^align_word(rx_shift_reg, word_len_sel)) != parity_type_sel);
            push_ent[urx_pkg::WORD_W+2] <= noise_acc | noisy;
         end
      end
   end

   // Two-deep receive buffer
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= '0;
      end else if (ce) begin
         if (push_ok) begin
            wr_ptr <= ptr_inc(wr_ptr);
         end
         if (pop) begin
            rd_ptr <= ptr_inc(rd_ptr);
         end
         if (push_ok && !pop) begin
            count <= count + CNT_W'(1);
         end else if (pop && !push_ok) begin
            count <= count - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (ce && push_ok) begin
         fifo_mem[wr_ptr] <= push_ent;
      end
   end

   // Overrun is sticky until status read then data read; a new overrun wins
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         overrun_flag <= 1'b0;
         clr_armed <= 1'b0;
      end else if (ce) begin
         if (rd_stat) begin
            clr_armed <= 1'b1;
         end else if (rd_dat) begin
            clr_armed <= 1'b0;
         end
         if (ovr_evt) begin
            overrun_flag <= 1'b1;
         end else if (rd_dat && clr_armed) begin
            overrun_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rx_idle_flag <= 1'b1;
      end else if (ce) begin
         if (start_det) begin
            rx_idle_flag <= 1'b0;
         end else if (fin || !rx_enable || ((state == urx_pkg::URX_START) && vote && maj)) begin
            rx_idle_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rx_irq <= 1'b0;
      end else if (ce) begin
         rx_irq <= rx_int_en && (push_ok || ovr_evt);
      end
   end

   // Register reads, data valid the cycle after the strobe
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= '0;
      end else if (ce) begin
         rd_data <= '0;
         if (rd_en && (addr == urx_pkg::ADDR_CTRL)) begin
            rd_data[urx_pkg::CTRL_W-1:0] <= serial_ctrl_one;
         end else if (rd_en && (addr == urx_pkg::ADDR_BAUD)) begin
            rd_data <= baud_divisor;
         end else if (rd_stat) begin
            rd_data[urx_pkg::SB_AVAIL] <= avail;
            rd_data[urx_pkg::SB_IDLE] <= rx_idle_flag;
            rd_data[urx_pkg::SB_OVR] <= overrun_flag;
            rd_data[urx_pkg::SB_NOISE] <= avail && head[urx_pkg::WORD_W+2];
            rd_data[urx_pkg::SB_FRAME_ERR_FLAG] <= avail && head[urx_pkg::WORD_W];
            rd_data[urx_pkg::SB_PARITY_ERR_FLAG] <= avail && head[urx_pkg::WORD_W+1];
            rd_data[urx_pkg::SB_NINTH] <= avail && head[urx_pkg::WORD_W-1];
         end else if (rd_dat && avail) begin
            rd_data[7:0] <= head[7:0];
         end
      end
   end

   avail_report_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ce && rd_stat |=> rd_data[urx_pkg::SB_AVAIL] == ($past(count) != '0))
      else $error("status avail bit disagrees with buffer fill");

   ovr_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ce && push && full && !pop |=> overrun_flag && (count == $past(count)))
      else $error("overrun not flagged or buffer changed");

   ovr_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ce && rd_stat ##1 ce && rd_dat && !ovr_evt |=> !overrun_flag)
      else $error("overrun not cleared by status then data read");

   irq_req_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ce && rx_int_en && (push_ok || ovr_evt) |=> rx_irq)
      else $error("receive request missing");

   hunt_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ce && !rx_enable |=> state == urx_pkg::URX_HUNT)
      else $error("receiver left hunt while disabled");

   break_wait_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ce && rx_enable && (state == urx_pkg::URX_WAITHI) && !line
      |=> state == urx_pkg::URX_WAITHI)
      else $error("low line taken as new start");

   idle_track_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ce && start_det |=> !rx_idle_flag ##0 (state == urx_pkg::URX_START))
      else $error("idle flag not dropped at start");

   pop_count_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ce && pop && !push_ok |=> count == $past(count) - CNT_W'(1))
      else $error("data read did not pop");

   frame_err_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      ce && fin && !maj |=> push_ent[urx_pkg::WORD_W])
      else $error("low stop bit without framing error");
endmodule
`default_nettype wire

// >>> tb/urx_tx_model.sv
// Behavioural serial transmitter that drives the receiver's line
`default_nettype none
module urx_tx_model (
   // Clock
   input wire logic clk_sys,
   // Serial line, idle high
   output logic rx_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial rx_pin = 1'b1;

   // Start, nb word bits, two stop slots; bit nz (none if negative) gets a glitch
   // Two clocks wide so it passes the synchroniser, late so only one sample sees it
   task automatic send(input logic [8:0] w, input int nb, input int per,
      input logic [1:0] stp, input int nz);
      logic v;
      logic g;
      for (int b = -1; b <= nb + 1; b++) begin
         v = (b < 0) ? 1'b0 : (b < nb) ? w[b] : stp[b - nb];
         for (int c = 0; c < per; c++) begin
            g = (nz >= 0) && (b == nz) && (c >= per / 2 + 2) && (c <= per / 2 + 3);
            @(posedge clk_sys);
            rx_pin <= g ? ~v : v;
         end
      end
      // Last slot gets its full length, then the line returns to idle high
      @(posedge clk_sys);
      rx_pin <= 1'b1;
   endtask

   // Long low line, then a high level so the receiver can rearm
   task automatic brk(input int n, input int per);
      @(posedge clk_sys);
      rx_pin <= 1'b0;
      repeat (n * per) @(posedge clk_sys);
      rx_pin <= 1'b1;
      repeat (per) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

// >>> tb/urx_receiver_test.sv
// Self-checking bench for the serial receiver against a queue model
`default_nettype none
module urx_receiver_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wr_data = 16'h0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic ce = 1'b1;
   logic [15:0] rd_data;
   logic rx_pin;
   logic rx_irq;
   logic [15:0] d;
   logic [5:0] ctrl = 6'h00;
   logic ovr = 1'b0;
   logic [11:0] exp_q[$];
   int per = 16;
   int irqs = 0;
   int exp_irq = 0;
   int mismatches = 0;
   int n_compared = 0;

   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (rx_irq === 1'b1) irqs++;

   urx_receiver u_dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_pin(rx_pin), .rx_irq(rx_irq)
   );
   urx_tx_model u_tx (.clk_sys(clk_sys), .rx_pin(rx_pin));

   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 v = rd_data;
   endtask

   task automatic wait_irq();
      for (int k = 0; k < 3000 && irqs < exp_irq; k++) @(posedge clk_sys);
      if (irqs < exp_irq) begin
         $display("MISMATCH irq wait expected %0d seen %0d", exp_irq, irqs);
         mismatches++;
         print_verdict();
      end
   endtask

   // Entry: [11] parity err, [10] framing err, [9] noise, [8] ninth bit, [7:0] data
   function automatic logic [11:0] mk(input logic [8:0] w, input logic nz, input logic fe);
      logic p;
      p = ^(ctrl[urx_pkg::CB_WL9] ? w : {1'b0, w[7:0]});
      mk = {ctrl[urx_pkg::CB_PAR_EN] & (p != ctrl[urx_pkg::CB_PAR_ODD]), fe, nz,
         ctrl[urx_pkg::CB_WL9] & w[8], w[7:0]};
   endfunction

   task automatic cfg(input logic [5:0] c, input int div);
      ctrl = c;
      per = 16 * (div + 1);
      wr(urx_pkg::ADDR_BAUD, 16'(div));
      wr(urx_pkg::ADDR_CTRL, {10'h000, c});
      rd(urx_pkg::ADDR_BAUD, d);
      chk("baud", d, 16'(div));
      rd(urx_pkg::ADDR_CTRL, d);
      chk("ctrl", d, {10'h000, c});
   endtask

   task automatic frame(input logic [8:0] w, input logic nz, input logic [1:0] stp);
      u_tx.send(w, ctrl[urx_pkg::CB_WL9] ? 9 : 8, per, stp, nz ? 3 : -1);
      if (exp_q.size() < 2) exp_q.push_back(mk(w, nz, ~stp[0] |
         (ctrl[urx_pkg::CB_STOP2] & ~stp[1])));
      else ovr = 1'b1;
      exp_irq++;
   endtask

   // Status then data read, as software must do
   task automatic check_pop();
      logic [11:0] e;
      logic [15:0] s;
      e = (exp_q.size() > 0) ? exp_q[0] : 12'h000;
      s = 16'h0002;
      s[urx_pkg::SB_AVAIL] = exp_q.size() > 0;
      s[urx_pkg::SB_OVR] = ovr;
      s[urx_pkg::SB_NOISE] = e[9];
      s[urx_pkg::SB_FRAME_ERR_FLAG] = e[10];
      s[urx_pkg::SB_PARITY_ERR_FLAG] = e[11];
      s[urx_pkg::SB_NINTH] = e[8];
      // Status and data strobes back to back, no gap between them
      @(posedge clk_sys);
      addr <= urx_pkg::ADDR_STAT;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      addr <= urx_pkg::ADDR_DATA;
      #1 chk("status", rd_data, s);
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 chk("data", rd_data, {8'h00, e[7:0]});
      if (exp_q.size() > 0) void'(exp_q.pop_front());
      ovr = 1'b0;
   endtask

   initial begin
      logic [8:0] w;
      logic [5:0] c;
      void'($urandom(32'h461D986C));
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      rd(urx_pkg::ADDR_STAT, d);
      chk("status", d, 16'h0002);
      rd(4'h2, d);
      chk("unmapped", d, 16'h0000);
      u_tx.send(9'h055, 8, 16, 2'b11, -1);
      check_pop();
      $display("test reset and disabled done");
      cfg(6'h21, 0);
      for (int i = 0; i < 3; i++) frame(9'($urandom), 1'b0, 2'b11);
      wait_irq();
      for (int i = 0; i < 3; i++) check_pop();
      chk("irqs", 16'(irqs), 16'(exp_irq));
      $display("test overrun done");
      for (int m = 0; m < 8; m++) begin
         c = 6'h25;
         c[urx_pkg::CB_PAR_ODD] = m[0];
         c[urx_pkg::CB_WL9] = m[2];
         cfg(c, m[2] ? 2 : 0);
         w = 9'($urandom);
         w[m[2] ? 8 : 7] ^= (^(m[2] ? w : {1'b0, w[7:0]})) ^ m[0] ^ m[1];
         frame(w, 1'b0, 2'b11);
         wait_irq();
         check_pop();
      end
      $display("test parity done");
      cfg(6'h31, 0);
      frame(9'($urandom), 1'b0, 2'b01);
      cfg(6'h21, 0);
      frame(9'($urandom), 1'b0, 2'b10);
      wait_irq();
      check_pop();
      check_pop();
      $display("test stop bits done");
      fork
         frame(9'($urandom), 1'b1, 2'b11);
         begin
            repeat (80) @(posedge clk_sys);
            rd(urx_pkg::ADDR_STAT, d);
            chk("busy status", d, 16'h0000);
         end
      join
      wait_irq();
      check_pop();
      chk("irqs", 16'(irqs), 16'(exp_irq));
      $display("test noise and idle done");
      u_tx.brk(14, per);
      exp_q.push_back(mk(9'h000, 1'b0, 1'b1));
      exp_irq++;
      frame(9'($urandom), 1'b0, 2'b11);
      wait_irq();
      check_pop();
      check_pop();
      chk("irqs", 16'(irqs), 16'(exp_irq));
      $display("test break done");
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(urx_pkg::ADDR_CTRL, 16'h0000);
      ce <= 1'b1;
      rd(urx_pkg::ADDR_CTRL, d);
      chk("frozen ctrl", d, 16'h0021);
      $display("test clock enable done");
      frame(9'($urandom), 1'b0, 2'b10);
      wait_irq();
      arst_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      exp_q.delete();
      check_pop();
      rd(urx_pkg::ADDR_CTRL, d);
      chk("ctrl after reset", d, 16'h0000);
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
